// >>> rre_exec.v
// Decode and execute of literal return, return and rotate-through-carry
`timescale 1ns/1ps
`default_nettype none
`include "rre_consts.vh"

module rre_exec (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        clk_en,
    input  wire        instr_valid,
    input  wire [13:0] instr,
    input  wire [12:0] stack_top,
    input  wire [7:0]  file_rdata,
    input  wire        carry_flag,
    output wire        busy,
    output reg         stack_pop,
    output reg         pc_load,
    output reg  [12:0] pc_value,
    output reg         fetch_flush,
    output reg         w_we,
    output reg  [7:0]  w_wdata,
    output reg         file_we,
    output reg  [6:0]  file_waddr,
    output reg  [7:0]  file_wdata,
    output reg         carry_we,
    output reg         carry_wdata,
    output wire [6:0]  file_raddr
);

    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    reg rst_s1_q;
    reg rst_s2_q;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // Release lags two edges so it never lands mid-instruction
    wire rst_int_n = rst_s2_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    localparam [1:0] ST_EXEC  = 2'h1;
    localparam [1:0] ST_FLUSH = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;

    wire is_retlit = (instr & `RRE_RETLIT_MSK) == `RRE_RETLIT_VAL;
    wire is_ret    = instr == `RRE_RET_VAL;
    wire is_ror    = (instr & `RRE_ROT_MSK) == `RRE_ROR_VAL;
    wire is_rol    = (instr & `RRE_ROT_MSK) == `RRE_ROL_VAL;
    wire dest_file = instr[`RRE_DEST_BIT];
    wire take      = instr_valid && (state_q == ST_EXEC);
    // Unrecognised words match neither class and write nothing
    wire do_return = take && (is_retlit || is_ret);
    wire do_rotate = take && (is_ror || is_rol);

    assign file_raddr = instr[`RRE_FADDR_HI:`RRE_FADDR_LO];
    // Core must hold off new instructions during the flush cycle
    assign busy       = (state_q == ST_FLUSH);

    wire [7:0] rot_res;
    wire       rot_cy;

    rre_rotator u_rot (
        .operand   (file_rdata),
        .carry_in  (carry_flag),
        .dir_left  (is_rol),
        .result    (rot_res),
        .carry_out (rot_cy)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_EXEC: begin
                if (do_return) begin
                    state_d = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                state_d = ST_EXEC;
            end
            default: begin
                state_d = ST_EXEC;
            end
        endcase
    end

    // Sequencer state register
    always @(posedge mclk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            state_q <= ST_EXEC;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // Next-value logic
    // ----------------------------------------
    // Next values of the output flops
    reg        stack_pop_d;
    reg        pc_load_d;
    reg [12:0] pc_value_d;
    reg        fetch_flush_d;
    reg        w_we_d;
    reg [7:0]  w_wdata_d;
    reg        file_we_d;
    reg [6:0]  file_waddr_d;
    reg [7:0]  file_wdata_d;
    reg        carry_we_d;
    reg        carry_wdata_d;

    always @* begin
        // Pulses drop by default; data outputs hold until the next write
        stack_pop_d   = 1'b0;
        pc_load_d     = 1'b0;
        pc_value_d    = pc_value;
        w_we_d        = 1'b0;
        w_wdata_d     = w_wdata;
        file_we_d     = 1'b0;
        file_waddr_d  = file_waddr;
        file_wdata_d  = file_wdata;
        carry_we_d    = 1'b0;
        carry_wdata_d = carry_wdata;
        // flush the fetch after the jump
        fetch_flush_d = (state_q == ST_FLUSH);
        if (do_return) begin
            // pop and jump to return address
            stack_pop_d = 1'b1;
            pc_load_d   = 1'b1;
            pc_value_d  = stack_top;
            if (is_retlit) begin
                w_we_d    = 1'b1;
                w_wdata_d = instr[`RRE_LIT_HI:`RRE_LIT_LO];
            end
        end else if (do_rotate) begin
            carry_we_d    = 1'b1;
            carry_wdata_d = rot_cy;
            if (dest_file) begin
                file_we_d    = 1'b1;
                file_waddr_d = instr[`RRE_FADDR_HI:`RRE_FADDR_LO];
                file_wdata_d = rot_res;
            end else begin
                w_we_d    = 1'b1;
                w_wdata_d = rot_res;
            end
        end
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    // Clock enable low freezes every output and state flop, strobes included, so a
    // stalled core sees the same request again when it resumes
    always @(posedge mclk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            // Strobes
            stack_pop   <= 1'b0;
            pc_load     <= 1'b0;
            fetch_flush <= 1'b0;
            w_we        <= 1'b0;
            file_we     <= 1'b0;
            carry_we    <= 1'b0;
            // Held data
            pc_value    <= 13'h0000;
            w_wdata     <= 8'h00;
            file_waddr  <= 7'h00;
            file_wdata  <= 8'h00;
            carry_wdata <= 1'b0;
        end else if (clk_en) begin
            // Strobes
            stack_pop   <= stack_pop_d;
            pc_load     <= pc_load_d;
            fetch_flush <= fetch_flush_d;
            w_we        <= w_we_d;
            file_we     <= file_we_d;
            carry_we    <= carry_we_d;
            // Held data
            pc_value    <= pc_value_d;
            w_wdata     <= w_wdata_d;
            file_waddr  <= file_waddr_d;
            file_wdata  <= file_wdata_d;
            carry_wdata <= carry_wdata_d;
        end
    end

endmodule // rre_exec
`default_nettype wire

// >>> rre_consts.vh
// Constants for the return and rotate execute block
`ifndef RRE_CONSTS_VH
`define RRE_CONSTS_VH

`define RRE_IW          14
`define RRE_PCW         13
// Return with literal: 11 01xx kkkk kkkk
`define RRE_RETLIT_MSK  14'h3c00
`define RRE_RETLIT_VAL  14'h3400
// Plain return: 00 0000 0000 1000
`define RRE_RET_VAL     14'h0008
// Rotate right: 00 1100 dfff ffff, rotate left: 00 1101 dfff ffff
`define RRE_ROT_MSK     14'h3f00
`define RRE_ROR_VAL     14'h0c00
`define RRE_ROL_VAL     14'h0d00
`define RRE_DEST_BIT    7
`define RRE_FADDR_HI    6
`define RRE_FADDR_LO    0
`define RRE_LIT_HI      7
`define RRE_LIT_LO      0
`define RRE_MSB         7
`define RRE_LSB         0

`endif

// >>> rre_rotator.v
// Rotate through carry datapath for one 8-bit operand
`timescale 1ns/1ps
`default_nettype none
`include "rre_consts.vh"

module rre_rotator (
    input  wire [7:0] operand,
    input  wire       carry_in,
    input  wire       dir_left,
    output wire [7:0] result,
    output wire       carry_out
);

    assign result    = dir_left ? {operand[`RRE_MSB-1:0], carry_in}
                                : {carry_in, operand[`RRE_MSB:`RRE_LSB+1]};
    assign carry_out = dir_left ? operand[`RRE_MSB] : operand[`RRE_LSB];

endmodule // rre_rotator
`default_nettype wire

// >>> rre_exec_assertions.sv
// Checker for the return and rotate execute block
`timescale 1ns/1ps
`default_nettype none
module rre_exec_chk (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        instr_valid,
    input wire logic [13:0] instr,
    input wire logic [12:0] stack_top,
    input wire logic [7:0]  file_rdata,
    input wire logic        carry_flag,
    input wire logic        busy,
    input wire logic        stack_pop,
    input wire logic        pc_load,
    input wire logic [12:0] pc_value,
    input wire logic        fetch_flush,
    input wire logic        w_we,
    input wire logic [7:0]  w_wdata,
    input wire logic        file_we,
    input wire logic [6:0]  file_waddr,
    input wire logic [7:0]  file_wdata,
    input wire logic        carry_we,
    input wire logic        carry_wdata,
    input wire logic [6:0]  file_raddr
);
    wire       tk  = clk_en && instr_valid && !busy;
    wire       lit = tk && instr[13:10] == 4'hd;
    wire       ret = tk && instr == 14'h0008;
    wire       ror = tk && instr[13:8] == 6'h0c;
    wire       rol = tk && instr[13:8] == 6'h0d;
    wire [7:0] wr  = w_we ? w_wdata : file_wdata;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_ret; lit || ret; endsequence
    sequence s_flush; busy ##1 (fetch_flush && !busy); endsequence
    AST_LIT_W: assert property (lit |=> w_we && w_wdata == $past(instr[7:0]))
        else $error("literal not placed in W");
    AST_LIT_PC: assert property (lit |=> pc_load && pc_value == $past(stack_top))
        else $error("literal return target wrong");
    AST_RET_FLUSH: assert property (s_ret |=> s_flush)
        else $error("return flush cycle wrong");
    AST_RET_POP: assert property (ret |=> stack_pop && pc_load && !w_we)
        else $error("plain return did not pop");
    AST_RET_FLAGS: assert property (s_ret |=> !carry_we [*2])
        else $error("return wrote carry");
    AST_ROR_DATA: assert property (ror |=> carry_wdata == $past(file_rdata[0])
        && wr == $past({carry_flag, file_rdata[7:1]})) else $error("right rotate wrong");
    AST_ROR_DEST: assert property (ror |=> file_we == $past(instr[7]) && w_we != file_we)
        else $error("right rotate destination wrong");
    AST_ROL_DATA: assert property (rol |=> carry_wdata == $past(file_rdata[7])
        && wr == $past({file_rdata[6:0], carry_flag})) else $error("left rotate wrong");
    AST_ROL_DEST: assert property (rol |=> file_we == $past(instr[7]) && w_we != file_we)
        else $error("left rotate destination wrong");
    AST_ROT_ONE: assert property ((ror || rol) |=> carry_we && !busy && !stack_pop
        && (!file_we || file_waddr == $past(instr[6:0]))) else $error("rotate side effect");
    AST_RADDR: assert property ((ror || rol) |-> file_raddr == instr[6:0])
        else $error("file read address wrong");
endmodule // rre_exec_chk
bind rre_exec rre_exec_chk chk_u (.mclk, .rst_n, .clk_en, .instr_valid, .instr, .stack_top,
    .file_rdata, .carry_flag, .busy, .stack_pop, .pc_load, .pc_value, .fetch_flush, .w_we,
    .w_wdata, .file_we, .file_waddr, .file_wdata, .carry_we, .carry_wdata, .file_raddr);
`default_nettype wire

// >>> return_and_rotate_exec_test.sv
// Self-checking bench for the return and rotate execute block
`timescale 1ns/1ps
`default_nettype none
module return_and_rotate_exec_test;
    logic        mclk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, instr_valid = 1'h0;
    logic        carry_flag = 1'h0, d;
    logic [13:0] instr = 14'h0;
    logic [12:0] stack_top = 13'h0;
    logic [7:0]  file_rdata = 8'h0;
    wire         busy, stack_pop, pc_load, fetch_flush, w_we, file_we, carry_we, carry_wdata;
    wire  [12:0] pc_value;
    wire  [7:0]  w_wdata, file_wdata;
    wire  [6:0]  file_waddr, file_raddr;
    int          n_mismatch = 0, tests_run = 0, cyc = 0, k, fr, cf, e, j;
    int          exp_q[$];
    rre_exec dut_u (.mclk, .rst_n, .clk_en, .instr_valid, .instr, .stack_top, .file_rdata,
        .carry_flag, .busy, .stack_pop, .pc_load, .pc_value, .fetch_flush, .w_we, .w_wdata,
        .file_we, .file_waddr, .file_wdata, .carry_we, .carry_wdata, .file_raddr);
    always #5 mclk = ~mclk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Ceiling well above 200 operations of at most two cycles each
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run;
        end
    end
    initial begin
        void'($urandom(32'h045691fd));
        repeat (6) @(posedge mclk);
        #1 rst_n = 1'h1;
        repeat (3) @(posedge mclk);
        #1;
        // Valid stays high so rotates run back to back
        repeat (200) begin
            k = $urandom % 4;
            instr = k == 0 ? {4'hd, 10'($urandom)} : k == 1 ? 14'h0008 : {5'h06, k[0], 8'($urandom)};
            stack_top = 13'($urandom);
            file_rdata = 8'($urandom);
            carry_flag = 1'($urandom);
            instr_valid = 1'h1;
            d = instr[7];
            // Integer model of rotate through carry, as {carry, byte}
            fr = file_rdata;
            cf = carry_flag;
            e = k[0] ? fr * 2 + cf : fr % 2 * 256 + cf * 128 + fr / 2;
            if (k > 1) exp_q.push_back(e);
            @(posedge mclk);
            #1;
            if (k < 2) begin
                chk({stack_pop, pc_load, w_we, file_we, carry_we, busy}, {2'h3, k == 0, 3'h1});
                chk(pc_value, stack_top);
                if (k == 0) chk(w_wdata, instr[7:0]);
                // Rotate offered in the busy cycle must be ignored
                instr = 14'h0d85;
                @(posedge mclk);
                #1;
                chk({fetch_flush, busy, carry_we, stack_pop, w_we}, 5'h10);
            end else begin
                e = exp_q.pop_front();
                // Clock enable held low for a cycle must freeze the strobes, busy, carry and the written result and address
                j = $urandom % 3 == 0;
                for (int r = 0; r <= j; r++) begin
                    chk({stack_pop, pc_load, w_we, file_we, carry_we, busy}, {2'h0, !d, d, 2'h2});
                    chk({carry_wdata, d ? file_wdata : w_wdata}, 16'(e));
                    if (d) chk(file_waddr, instr[6:0]);
                    chk(file_raddr, instr[6:0]);
                    if (r < j) begin
                        clk_en = 1'h0;
                        @(posedge mclk);
                        #1;
                    end
                end
                clk_en = 1'h1;
            end
        end
        complete_run;
    end
endmodule // return_and_rotate_exec_test
`default_nettype wire
